// file: shared/eight_bit_preload_timer_pkg.sv
package eight_bit_preload_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int COUNT_W   = 8;
  localparam int PSC_SEL_W = 3;
  localparam int PSC_CNT_W = 7;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNT_VALUE   = 8'h04;
  localparam logic [7:0] OFF_IRQ_CONTROL   = 8'h08;
  localparam int         DECODE_W          = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTL_PSC_LSB   = 0;
  localparam int CTL_ENABLE    = 4;
  localparam int CTL_SRC_SEL   = 5;
  localparam int IRQ_EN_BIT    = 0;
  localparam int IRQ_FLAG_BIT  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Values
  localparam logic [COUNT_W-1:0]   COUNT_FULL     = 8'hff;
  localparam logic [COUNT_W-1:0]   COUNT_RESET    = 8'h00;
  localparam logic [PSC_CNT_W-1:0] PSC_CNT_RESET  = 7'h00;
  localparam logic [PSC_CNT_W-1:0] PSC_ONE        = 7'h01;
  localparam logic [PSC_CNT_W-1:0] PSC_MASK_BASE  = 7'h7f;
  localparam logic [DATA_W-1:0]    RDATA_ZERO     = 32'h0000_0000;
  localparam logic [1:0]           HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]           HRESP_OKAY     = 2'h0;
  localparam int                   PSC_MAX_CODE   = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields as they travel through the block
  typedef struct packed {
    logic                 clock_source_select;
    logic                 count_enable;
    logic [PSC_SEL_W-1:0] prescale_ratio_select;
  } timer_control_t;

  localparam timer_control_t CONTROL_RESET = '{1'b0, 1'b0, 3'h0};

  typedef struct packed {
    logic timer_irq_enable;
    logic request_flag;
  } irq_control_t;

  localparam irq_control_t IRQ_RESET = '{1'b0, 1'b0};

endpackage

// file: verilog/eight_bit_preload_timer.sv
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Source select 0 counts on the system clock, 1 on the sub clock.
// R2 - Three-bit prescale code divides the source by 1, 2, 4 up to 128.
// R3 - Counter adds one per prescaled tick while counting is enabled.
// R4 - Counter advances on the falling edge of the prescaled timer clock.
// R5 - Passing FFH signals overflow, raises request, reloads from preload, keeps counting.
// R6 - Write while stopped goes into both preload and working counter.
// R7 - Write while running updates preload only; counter takes it at next overflow.
// R8 - Counting runs only while control bit 4 is high.
// R9 - Control bits 7 to 6 and bit 3 read as zero.
// R10 - Overflow sets the request flag; interrupt passes only when enabled.
// R11 - Clearing the timer interrupt enable keeps the interrupt inactive.
// R12 - An overflow with the request flag clear requests wake-up from power-down regardless of interrupt enable.
// R13 - Software sets the request flag before power-down to prevent overflow wake-up.
// R14 - Timer clock is inhibited while software reads counter or writes preload.
// R15 - Software loads an initial count before enabling the timer.
// R16 - Software clears the preload to zero for the full 256-step range.
// R17 - Reading the timer register returns the working counter, not the preload.
// R18 - Overflow indication to interrupt and wake-up is one pulse per overflow.

module eight_bit_preload_timer (
  // Clock, reset, clock enable
  input  wire logic                                              hclk,
  input  wire logic                                              hresetn,
  input  wire logic                                              clk_en,
  // Low-frequency sub clock from its oscillator pin
  input  wire logic                                              sub_clk_pin,
  // AHB-Lite slave
  input  wire logic                                              hsel,
  input  wire logic [eight_bit_preload_timer_pkg::ADDR_W-1:0]    haddr,
  input  wire logic [1:0]                                        htrans,
  input  wire logic                                              hwrite,
  input  wire logic [2:0]                                        hsize,
  input  wire logic [eight_bit_preload_timer_pkg::DATA_W-1:0]    hwdata,
  input  wire logic                                              hready,
  output logic                                                   hreadyout,
  output logic [1:0]                                             hresp,
  output logic [eight_bit_preload_timer_pkg::DATA_W-1:0]         hrdata,
  // Events
  output logic                                                   timer_irq,
  output logic                                                   wake_req,
  output logic                                                   overflow_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  eight_bit_preload_timer_pkg::timer_control_t             ctrl_reg;
  eight_bit_preload_timer_pkg::irq_control_t               irq_reg;
  logic [eight_bit_preload_timer_pkg::COUNT_W-1:0]         count_reg;
  logic [eight_bit_preload_timer_pkg::COUNT_W-1:0]         preload_reg;
  logic [eight_bit_preload_timer_pkg::PSC_CNT_W-1:0]       psc_reg;

  // Timer chain
  logic [eight_bit_preload_timer_pkg::PSC_CNT_W-1:0]       psc_mask;
  logic                                                    sub_meta_reg;
  logic                                                    sub_sync_reg;
  logic                                                    sub_prev_reg;
  logic                                                    sub_rise;
  logic                                                    src_tick;
  logic                                                    timer_tick;
  logic                                                    count_tick;
  logic                                                    overflow;
  logic                                                    inhibit;

  // Bus side
  logic                                                    addr_ok;
  logic                                                    wr_pend_reg;
  logic [eight_bit_preload_timer_pkg::DECODE_W-1:0]        wr_addr_reg;
  logic                                                    wr_ctrl;
  logic                                                    wr_count;
  logic                                                    wr_irq;
  logic                                                    rd_count;
  logic [eight_bit_preload_timer_pkg::DATA_W-1:0]          rdata_next;
  logic [eight_bit_preload_timer_pkg::COUNT_W-1:0]         wdata_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Sub clock synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_meta_reg <= 1'b0;
      sub_sync_reg <= 1'b0;
    end else if (clk_en) begin
      sub_meta_reg <= sub_clk_pin;
      sub_sync_reg <= sub_meta_reg;
    end
  end

  // Edge history; a pin high at reset gives one edge, but the timer is still off then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sub_prev_reg <= sub_sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and prescaler
  // Sub clock must be well below hclk/2 or its edges are lost in sampling
  assign sub_rise = sub_sync_reg & ~sub_prev_reg;

  always_comb begin
    if (ctrl_reg.clock_source_select) begin
      src_tick = sub_rise; // R1
    end else begin
      src_tick = 1'b1; // R1
    end
  end

  // Mask of the low prescaler bits; all ones there means the selected bit falls next
  assign psc_mask = eight_bit_preload_timer_pkg::PSC_MASK_BASE >>
                    (eight_bit_preload_timer_pkg::PSC_MAX_CODE -
                     int'(ctrl_reg.prescale_ratio_select)); // R2

  // Prescaler restarts on every enable, so the first period is a whole one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_reg <= eight_bit_preload_timer_pkg::PSC_CNT_RESET;
    end else if (clk_en) begin
      if (!ctrl_reg.count_enable) begin
        psc_reg <= eight_bit_preload_timer_pkg::PSC_CNT_RESET;
      end else if (src_tick) begin
        psc_reg <= psc_reg + eight_bit_preload_timer_pkg::PSC_ONE; // R2
      end
    end
  end

  // High-to-low transition of the divided clock
  assign timer_tick = src_tick && ((psc_reg & psc_mask) == psc_mask); // R4

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Every register answers without wait states
  assign hreadyout = 1'b1;
  assign hresp     = eight_bit_preload_timer_pkg::HRESP_OKAY;
  assign addr_ok   = hsel && hready && (htrans == eight_bit_preload_timer_pkg::HTRANS_NONSEQ);
  assign rd_count  = addr_ok && !hwrite &&
                     (haddr[eight_bit_preload_timer_pkg::DECODE_W-1:0] ==
                      eight_bit_preload_timer_pkg::OFF_COUNT_VALUE);
  assign wr_ctrl   = wr_pend_reg &&
                     (wr_addr_reg == eight_bit_preload_timer_pkg::OFF_TIMER_CONTROL);
  assign wr_count  = wr_pend_reg &&
                     (wr_addr_reg == eight_bit_preload_timer_pkg::OFF_COUNT_VALUE);
  assign wr_irq    = wr_pend_reg &&
                     (wr_addr_reg == eight_bit_preload_timer_pkg::OFF_IRQ_CONTROL);
  assign wdata_byte = hwdata[eight_bit_preload_timer_pkg::COUNT_W-1:0];

  // Writes complete in the data phase, one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
    end else if (clk_en) begin
      wr_pend_reg <= addr_ok && hwrite;
    end
  end

  // Address kept for the data phase; a read refreshes it harmlessly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_reg <= '0;
    end else if (clk_en && addr_ok) begin
      wr_addr_reg <= haddr[eight_bit_preload_timer_pkg::DECODE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count qualification
  // Counter read capture and preload write both hold off the count; a tick may be lost
  assign inhibit    = rd_count || wr_count; // R14
  assign count_tick = timer_tick && ctrl_reg.count_enable && !inhibit; // R3 R8
  assign overflow   = count_tick && (count_reg == eight_bit_preload_timer_pkg::COUNT_FULL); // R5

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  // Unwritten bits have no storage, so they always read back as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= eight_bit_preload_timer_pkg::CONTROL_RESET;
    end else if (clk_en && wr_ctrl) begin
      ctrl_reg.clock_source_select   <= hwdata[eight_bit_preload_timer_pkg::CTL_SRC_SEL];
      ctrl_reg.count_enable          <= hwdata[eight_bit_preload_timer_pkg::CTL_ENABLE]; // R8
      ctrl_reg.prescale_ratio_select <=
        hwdata[eight_bit_preload_timer_pkg::CTL_PSC_LSB +: eight_bit_preload_timer_pkg::PSC_SEL_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Preload register
  // Taken on every write; only a stopped timer copies it straight on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preload_reg <= eight_bit_preload_timer_pkg::COUNT_RESET;
    end else if (clk_en && wr_count) begin
      preload_reg <= wdata_byte; // R6 R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working counter
  // A running write never touches the counter, so the reload picks it up later
  // A stopped write beats the reload, and the reload beats the increment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= eight_bit_preload_timer_pkg::COUNT_RESET;
    end else if (clk_en) begin
      if (wr_count && !ctrl_reg.count_enable) begin
        count_reg <= wdata_byte; // R6
      end else if (overflow) begin
        count_reg <= preload_reg; // R5 R7
      end else if (count_tick) begin
        count_reg <= count_reg + 8'h01; // R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request flag and enable
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= eight_bit_preload_timer_pkg::IRQ_RESET;
    end else if (clk_en) begin
      if (wr_irq) begin
        irq_reg.timer_irq_enable <= hwdata[eight_bit_preload_timer_pkg::IRQ_EN_BIT];
      end
      if (overflow) begin
        irq_reg.request_flag <= 1'b1; // R10
      end else if (wr_irq) begin
        irq_reg.request_flag <= hwdata[eight_bit_preload_timer_pkg::IRQ_FLAG_BIT]; // R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs, registered single pulses
  // Cleared while frozen, so one overflow never shows as a long pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_pulse <= 1'b0;
    end else if (clk_en) begin
      overflow_pulse <= overflow; // R18
    end else begin
      overflow_pulse <= 1'b0;
    end
  end

  // A flag already set by software masks the wake-up, the enable does not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_req <= 1'b0;
    end else if (clk_en) begin
      wake_req <= overflow && !irq_reg.request_flag; // R12 R13
    end else begin
      wake_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line, registered so it never glitches on a flag write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else if (clk_en) begin
      timer_irq <= irq_reg.request_flag && irq_reg.timer_irq_enable; // R10 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the address phase and shown in the data phase
  always_comb begin
    rdata_next = eight_bit_preload_timer_pkg::RDATA_ZERO;
    unique case (haddr[eight_bit_preload_timer_pkg::DECODE_W-1:0])
      eight_bit_preload_timer_pkg::OFF_TIMER_CONTROL: begin
        rdata_next[eight_bit_preload_timer_pkg::CTL_SRC_SEL] = ctrl_reg.clock_source_select;
        rdata_next[eight_bit_preload_timer_pkg::CTL_ENABLE]  = ctrl_reg.count_enable; // R9
        rdata_next[eight_bit_preload_timer_pkg::CTL_PSC_LSB +:
                   eight_bit_preload_timer_pkg::PSC_SEL_W]   = ctrl_reg.prescale_ratio_select;
      end
      eight_bit_preload_timer_pkg::OFF_COUNT_VALUE: begin
        rdata_next[eight_bit_preload_timer_pkg::COUNT_W-1:0] = count_reg; // R17
      end
      eight_bit_preload_timer_pkg::OFF_IRQ_CONTROL: begin
        rdata_next[eight_bit_preload_timer_pkg::IRQ_EN_BIT]   = irq_reg.timer_irq_enable;
        rdata_next[eight_bit_preload_timer_pkg::IRQ_FLAG_BIT] = irq_reg.request_flag;
      end
      default: begin
        rdata_next = eight_bit_preload_timer_pkg::RDATA_ZERO;
      end
    endcase
  end

  // Held until the next read address phase is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= eight_bit_preload_timer_pkg::RDATA_ZERO;
    end else if (clk_en && addr_ok && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

endmodule

// file: tb/eight_bit_preload_timer_assertions.sv
`timescale 1ns/1ps
module eight_bit_preload_timer_assertions (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        sub_clk_pin,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [1:0]  hresp,
  input wire logic [31:0] hrdata,
  // Events
  input wire logic        timer_irq,
  input wire logic        wake_req,
  input wire logic        overflow_pulse
);
  logic       take;
  logic       wr_phase_reg;
  logic [7:0] wr_addr_reg;
  logic       on_reg;
  logic [7:0] held_reg;
  logic       held_ok_reg;

  assign take = hsel && hready && htrans == 2'h2 && clk_en;

  // Shadow of the bus writes; the held count is only known while stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_reg <= 1'b0;
      wr_addr_reg  <= 8'h00;
    end else if (clk_en) begin
      wr_phase_reg <= take && hwrite;
      wr_addr_reg  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_reg      <= 1'b0;
      held_reg    <= 8'h00;
      held_ok_reg <= 1'b1;
    end else if (clk_en && wr_phase_reg) begin
      if (wr_addr_reg == 8'h00) begin
        on_reg <= hwdata[4];
        if (hwdata[4]) held_ok_reg <= 1'b0;
      end
      if (wr_addr_reg == 8'h04 && !on_reg) begin
        held_reg    <= hwdata[7:0];
        held_ok_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ready_okay_a: assert property (hreadyout && hresp == 2'h0)
    else $error("bus answer not ready or not okay");
  ctl_read_zero_a: assert property (
    take && !hwrite && haddr == 32'h0 |=> hrdata[31:6] == 26'h0 && !hrdata[3])
    else $error("unused control bits read nonzero");
  count_held_a: assert property (
    take && !hwrite && haddr == 32'h4 && held_ok_reg |=> hrdata == {24'h0, $past(held_reg)})
    else $error("stopped counter differs from written value");
  irq_mirror_a: assert property (
    take && !hwrite && haddr == 32'h8 |=> timer_irq == (hrdata[0] & hrdata[1]))
    else $error("interrupt does not follow flag and enable");
  ovf_needs_on_a: assert property (
    overflow_pulse |-> $past(on_reg) || $past(on_reg, 2))
    else $error("overflow while counting disabled");
  wake_with_ovf_a: assert property (wake_req |-> overflow_pulse)
    else $error("wake request without overflow");
  wake_single_a: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  unmapped_zero_a: assert property (take && !hwrite && haddr == 32'hc |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule

bind eight_bit_preload_timer eight_bit_preload_timer_assertions chk (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .sub_clk_pin(sub_clk_pin),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .timer_irq(timer_irq), .wake_req(wake_req),
  .overflow_pulse(overflow_pulse));

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        sub_clk_pin = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0]  hresp;
  logic        hreadyout;
  logic        timer_irq;
  logic        wake_req;
  logic        overflow_pulse;
  logic [31:0] rd;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          n;

  always #2.5 hclk = ~hclk;

  eight_bit_preload_timer dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .sub_clk_pin(sub_clk_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_irq(timer_irq),
    .wake_req(wake_req), .overflow_pulse(overflow_pulse));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // Bounded so a silent counter cannot hang the run
  task automatic wait_ovf();
    int k;
    k = 0;
    while (overflow_pulse !== 1'b1 && k < 600) begin
      @(posedge hclk);
      k++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("control", 32'h0, 32'h0);
    rd_chk("count", 32'h4, 32'h0);
    rd_chk("irq_ctl", 32'h8, 32'h0);
    bus(1'b1, 32'hc, 32'hff);
    rd_chk("unmapped", 32'hc, 32'h0);
    bus(1'b1, 32'h0, 32'hff);
    rd_chk("control_bits", 32'h0, 32'h37);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h4, 32'h5a);
    rd_chk("count_stopped", 32'h4, 32'h5a);
    // Each code: window of 64 << code cycles gives exactly 64 advances
    for (n = 0; n <= 7; n++) begin
      bus(1'b1, 32'h4, 32'h0);
      bus(1'b1, 32'h0, 32'h10 | n);
      repeat ((64 << n) - 2) @(posedge hclk);
      bus(1'b1, 32'h0, n);
      bus(1'b0, 32'h4, 32'h0);
      check("prescale", rd, 32'h40);
      repeat (20) @(posedge hclk);
      rd_chk("stopped_hold", 32'h4, rd);
    end
    bus(1'b1, 32'h4, 32'hf0);
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b1, 32'h0, 32'h10);
    bus(1'b1, 32'h4, 32'h80);
    bus(1'b0, 32'h4, 32'h0);
    check("no_early_load", rd, 32'hf1);
    wait_ovf();
    check("wake", 32'(wake_req), 32'h1);
    @(posedge hclk);
    check("ovf_width", 32'(overflow_pulse), 32'h0);
    bus(1'b0, 32'h4, 32'h0);
    check("reload", rd, 32'h82);
    rd_chk("irq_ctl_set", 32'h8, 32'h3);
    check("irq", 32'(timer_irq), 32'h1);
    wait_ovf();
    check("wake_flag_set", 32'(wake_req), 32'h0);
    bus(1'b1, 32'h8, 32'h2);
    repeat (2) @(posedge hclk);
    check("irq_masked", 32'(timer_irq), 32'h0);
    rd_chk("flag_kept", 32'h8, 32'h2);
    // Sub clock source: one advance per synchronised rising edge, pulsed well below hclk/2
    bus(1'b1, 32'h0, 32'h20);
    bus(1'b1, 32'h4, 32'h0);
    bus(1'b1, 32'h0, 32'h30);
    for (n = 0; n < 40; n++) begin
      sub_clk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      sub_clk_pin <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    // A pulse while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    sub_clk_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    sub_clk_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    clk_en <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1'b1, 32'h0, 32'h20);
    bus(1'b0, 32'h4, 32'h0);
    check("sub_source", rd, 32'h28);
    print_verdict();
  end
endmodule
